// *** verilog/serial_shift_pkg.sv ***
// constants shared by the universal serial shift unit and its bench
// assumes a 20 MHz system clock and a 32-bit apb register bus
`default_nettype none

package serial_shift_pkg;

    // ******************************************************
    // register byte offsets
    // ******************************************************
    localparam logic [3:0] DATA_OFFSET   = 4'h0; // shift register
    localparam logic [3:0] STATUS_OFFSET = 4'h4; // flags and counter
    localparam logic [3:0] CTRL_OFFSET   = 4'h8; // mode and strobes

    // ******************************************************
    // field positions
    // ******************************************************
    localparam int START_FLAG_BIT = 7; // status: start detect flag
    localparam int OVF_FLAG_BIT   = 6; // status: overflow flag
    localparam int WM_LSB         = 4; // ctrl: wire mode field
    localparam int CS_LSB         = 2; // ctrl: clock source field
    localparam int SW_CLK_BIT     = 1; // ctrl: software clock strobe
    localparam int TOGGLE_BIT     = 0; // ctrl: counter-only strobe

    // ******************************************************
    // encodings and reset values
    // ******************************************************
    localparam logic [1:0] WM_OFF   = 2'h0; // outputs off
    localparam logic [1:0] WM_THREE = 2'h1; // three-wire
    localparam logic [1:0] WM_TWO   = 2'h2; // two-wire, start hold
    localparam logic [1:0] WM_TWO_H = 2'h3; // two-wire, both holds
    localparam logic [1:0] CS_SOFT  = 2'h0; // software strobe
    localparam logic [1:0] CS_TIMER = 2'h1; // companion timer
    localparam logic [3:0] CNT_MAX  = 4'hf; // wrap point
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // ******************************************************
    // timing: data line delay for start detection
    // ******************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SDA_DELAY_NS  = 50; // least delay
    localparam int SDA_DLY_CYC   =
        (SDA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : serial_shift_pkg

`default_nettype wire

// *** verilog/universal_serial_shift_unit.sv ***
// universal serial shift unit: shift register, edge counter,
// clock hold and start detector behind an apb slave
// assumes pins arrive unsynchronised and open-drain wires are
// resolved outside from the output enables
//
// Chosen here: the APB slave port and the placing of the registers.
`default_nettype none

module universal_serial_shift_unit
    import serial_shift_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // companion timer overflow, same clock
    input  wire logic        TIMER_OVF,
    // serial pins
    input  wire logic        SERIAL_CLOCK_PIN,
    input  wire logic        SERIAL_DATA_IN_PIN,
    output logic             DATA_OUT,
    output logic             DATA_OE,
    output logic             CLOCK_OUT,
    output logic             CLOCK_OE
);

    // ******************************************************
    // state
    // ******************************************************
    logic [7:0]  shift_reg;        // serial_shift_data
    logic [7:0]  shift_next;       // value after this cycle
    logic [3:0]  cnt_reg;          // edge counter
    logic        start_flag_reg;   // start_detect_flag
    logic        ovf_flag_reg;     // counter_overflow_flag
    logic [1:0]  wm_reg;           // wire_mode_field
    logic [1:0]  cs_reg;           // clock_source_select
    logic        hold_start_reg;   // clock hold after start
    logic        hold_ovf_reg;     // clock hold after overflow
    logic        latch_reg;        // output latch
    logic        sck_s1_reg;       // clock pin sync stage 1
    logic        sck_s2_reg;       // clock pin sync stage 2
    logic        sck_d_reg;        // clock pin last sample
    logic        sda_s1_reg;       // data pin sync stage 1
    logic        sda_s2_reg;       // data pin sync stage 2
    logic [SDA_DLY_CYC-1:0] sda_dly_reg; // delayed data line
    logic [SDA_DLY_CYC:0]   sda_dly_cat; // delay line plus newest sample
    logic        sda_dprev_reg;    // delayed data, one older

    // ******************************************************
    // bus decode
    // ******************************************************
    logic        acc;              // access edge of a transfer
    logic        wr_data;          // data register write
    logic        wr_stat;          // status register write
    logic        wr_ctrl;          // control register write
    logic        mapped;           // address hits a register
    logic        sw_clk;           // software clock strobe
    logic        tgl;              // counter-only strobe
    logic        clr_start;        // write-one to start flag
    logic        clr_ovf;          // write-one to overflow flag

    assign acc     = PSEL & PENABLE & PREADY;
    assign mapped  = (PADDR[7:4] == 4'h0) &
                     ((PADDR[3:0] == DATA_OFFSET) |
                      (PADDR[3:0] == STATUS_OFFSET) |
                      (PADDR[3:0] == CTRL_OFFSET));
    assign wr_data = acc & PWRITE & (PADDR == {4'h0, DATA_OFFSET});
    assign wr_stat = acc & PWRITE & (PADDR == {4'h0, STATUS_OFFSET});
    assign wr_ctrl = acc & PWRITE & (PADDR == {4'h0, CTRL_OFFSET});
    assign sw_clk  = wr_ctrl & PWDATA[SW_CLK_BIT];
    assign tgl     = wr_ctrl & PWDATA[TOGGLE_BIT];
    assign clr_start = wr_stat & PWDATA[START_FLAG_BIT];
    assign clr_ovf   = wr_stat & PWDATA[OVF_FLAG_BIT];

    // ******************************************************
    // pin synchronisers
    // ******************************************************
    // two flops per pin; no glitch filter on purpose
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            sck_s1_reg <= 1'b1;
            sck_s2_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end else begin
            sck_s1_reg <= SERIAL_CLOCK_PIN;
            sck_s2_reg <= sck_s1_reg;
            sda_s1_reg <= SERIAL_DATA_IN_PIN;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    // edge history and the data line delay
    assign sda_dly_cat = {sda_dly_reg, sda_s2_reg};
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            sck_d_reg     <= 1'b1;
            sda_dly_reg   <= '1;
            sda_dprev_reg <= 1'b1;
        end else begin
            sck_d_reg     <= sck_s2_reg;
            sda_dly_reg   <= sda_dly_cat[SDA_DLY_CYC-1:0];
            sda_dprev_reg <= sda_dly_reg[SDA_DLY_CYC-1];
        end
    end

    // ******************************************************
    // clock source selection
    // ******************************************************
    logic sck_rise;    // clock pin rose
    logic sck_fall;    // clock pin fell
    logic ext_sel;     // clock_source_external_select
    logic shift_en;    // shift this cycle
    logic count_en;    // count this cycle
    logic ovf_event;   // counter wraps 15 to 0

    assign sck_rise = sck_s2_reg & ~sck_d_reg;
    assign sck_fall = ~sck_s2_reg & sck_d_reg;
    assign ext_sel  = cs_reg[1];

    // pin edges act in every wire mode
    // rising edge sample for cs 10, falling for 11
    assign shift_en = ((cs_reg == CS_SOFT) & sw_clk) |
                      ((cs_reg == CS_TIMER) & TIMER_OVF) |
                      (ext_sel & (cs_reg[0] ? sck_fall : sck_rise));
    // external clock counts both edges
    // timer overflow chains counter onto the timer
    assign count_en = ((cs_reg == CS_SOFT) & sw_clk) |
                      ((cs_reg == CS_TIMER) & TIMER_OVF) |
                      (ext_sel & (sck_rise | sck_fall | tgl));
    // preset F overflows on next event
    assign ovf_event = count_en & (cnt_reg == CNT_MAX) & ~wr_stat;

    // ******************************************************
    // shift register
    // ******************************************************
    // left shift from di; cpu write wins
    always_comb begin
        shift_next = shift_reg;
        if (wr_data) begin
            shift_next = PWDATA[7:0];
        end else if (shift_en) begin
            shift_next = {shift_reg[6:0], sda_s2_reg};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            shift_reg <= DATA_RST;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // ******************************************************
    // counter and overflow flag
    // ******************************************************
    // cpu load wins over counting; a load of 14 acks
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            cnt_reg <= 4'h0;
        end else if (wr_stat) begin
            cnt_reg <= PWDATA[3:0];
        end else if (count_en) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    // write-one clear wins, as a status write blocks the set
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ovf_flag_reg <= 1'b0;
        end else if (ovf_event) begin
            ovf_flag_reg <= 1'b1;
        end else if (clr_ovf) begin
            ovf_flag_reg <= 1'b0;
        end
    end

    // ******************************************************
    // start detector and clock holds
    // ******************************************************
    logic start_det;   // delayed data fell while clock high
    logic two_wire;    // two-wire mode selected

    assign two_wire  = wm_reg[1];
    // free of clock gating; enabled only by the two-wire mode
    // a new start only sets the flag again; counter and shift register are not reset
    assign start_det = two_wire & sck_s2_reg &
                       sda_dprev_reg & ~sda_dly_reg[SDA_DLY_CYC-1];

    // start flag, set wins over clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            start_flag_reg <= 1'b0;
        end else if (start_det) begin
            start_flag_reg <= 1'b1;
        end else if (clr_start) begin
            start_flag_reg <= 1'b0;
        end
    end

    // hold after start once master drives clock low
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            hold_start_reg <= 1'b0;
        end else if (~two_wire) begin
            hold_start_reg <= 1'b0;
        end else if ((start_flag_reg | start_det) & sck_fall) begin
            hold_start_reg <= 1'b1;
        end else if (clr_start) begin
            hold_start_reg <= 1'b0;
        end
    end

    // hold after overflow in mode 11
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            hold_ovf_reg <= 1'b0;
        end else if (wm_reg != WM_TWO_H) begin
            hold_ovf_reg <= 1'b0;
        end else if (ovf_event) begin
            hold_ovf_reg <= 1'b1;
        end else if (clr_ovf) begin
            hold_ovf_reg <= 1'b0;
        end
    end

    // ******************************************************
    // output latch and pins
    // ******************************************************
    logic latch_open;  // latch transparent
    // open in the half after the change edge, always when
    // internally clocked
    assign latch_open = ~ext_sel | (sck_s2_reg == cs_reg[0]);

    // fresh msb passes an open latch at once
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            latch_reg <= 1'b1;
        end else if (latch_open) begin
            latch_reg <= shift_next[7];
        end
    end

    // pin drivers; two-wire pins are open drain
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            DATA_OUT  <= 1'b0;
            DATA_OE   <= 1'b0;
            CLOCK_OUT <= 1'b0;
            CLOCK_OE  <= 1'b0;
        end else begin
            CLOCK_OUT <= 1'b0;
            case (wm_reg)
                WM_THREE: begin // push-pull data out
                    DATA_OUT <= latch_reg;
                    DATA_OE  <= 1'b1;
                    CLOCK_OE <= 1'b0;
                end
                WM_TWO, WM_TWO_H: begin // pull low only
                    DATA_OUT <= 1'b0;
                    DATA_OE  <= ~latch_reg;
                    CLOCK_OE <= hold_start_reg | hold_ovf_reg;
                end
                default: begin // outputs off
                    DATA_OUT <= 1'b0;
                    DATA_OE  <= 1'b0;
                    CLOCK_OE <= 1'b0;
                end
            endcase
        end
    end

    // ******************************************************
    // control register and apb answer
    // ******************************************************
    // mode and source fields steer the block
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            {wm_reg, cs_reg} <= CTRL_RST[5:2];
        end else if (wr_ctrl) begin
            wm_reg <= PWDATA[WM_LSB+1:WM_LSB];
            cs_reg <= PWDATA[CS_LSB+1:CS_LSB];
        end
    end

    // one wait-free access phase; read data latched at setup
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~mapped;
            PRDATA  <= 32'h0000_0000;
            if (PSEL & ~PENABLE & ~PWRITE) begin
                case (PADDR)
                    {4'h0, DATA_OFFSET}:   PRDATA[7:0] <= shift_reg;
                    {4'h0, STATUS_OFFSET}: PRDATA[7:0] <=
                        {start_flag_reg, ovf_flag_reg, 2'h0, cnt_reg};
                    {4'h0, CTRL_OFFSET}:   PRDATA[5:0] <=
                        {wm_reg, cs_reg, 2'h0};
                    default: PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence ovf_in_hold_mode_s;
        ovf_event && (wm_reg == WM_TWO_H);
    endsequence

    sequence start_then_fall_s;
        start_flag_reg ##0 (sck_fall && two_wire && !clr_start);
    endsequence

    overflow_sets_a: assert property (
        ovf_event |=> ovf_flag_reg && (cnt_reg == 4'h0))
        else $error("overflow flag not set on wrap");

    write_wins_a: assert property (
        wr_data |=> shift_reg == $past(PWDATA[7:0]))
        else $error("cpu write lost to shift");

    left_shift_a: assert property (
        (shift_en && !wr_data) |=>
            shift_reg == {$past(shift_reg[6:0]), $past(sda_s2_reg)})
        else $error("shift not left from data input");

    start_flag_a: assert property (
        start_det |=> start_flag_reg)
        else $error("start flag not set");

    start_hold_a: assert property (
        start_then_fall_s |=> hold_start_reg ##1 CLOCK_OE)
        else $error("clock not held after start");

    ovf_hold_a: assert property (
        ovf_in_hold_mode_s |=> hold_ovf_reg ##1 CLOCK_OE)
        else $error("clock not held after overflow");

    ovf_release_a: assert property (
        (clr_ovf && !ovf_event) |=> !ovf_flag_reg && !hold_ovf_reg)
        else $error("overflow clear did not release");

    start_release_a: assert property (
        (clr_start && !start_det && !sck_fall) |=>
            !start_flag_reg && !hold_start_reg)
        else $error("start clear did not release");

    both_edges_a: assert property (
        (ext_sel && (sck_rise || sck_fall) && !wr_stat) |=>
            cnt_reg == $past(cnt_reg) + 4'h1)
        else $error("external edge not counted");

    latch_open_a: assert property (
        (!ext_sel && (wm_reg == WM_THREE)) [*2] |=>
            DATA_OUT == $past(shift_reg[7]))
        else $error("open latch did not follow msb");

endmodule : universal_serial_shift_unit

`default_nettype wire

// *** sim/serial_bus_master_model.sv ***
// bus master model driving the serial clock and data lines
// assumes the bench resolves the open-drain wires and feeds them back
`default_nettype none

module serial_bus_master_model (
    // lines as the master sees them
    input  wire logic scl_wire,
    input  wire logic sda_wire,
    // master drive, 1 = released on an open-drain wire
    output logic      scl_drv,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;

    // ********************************
    // link timing and state
    // ********************************
    localparam int HALF = 200; // half of a 400 ns clock
    int            stalls = 0; // clock waits that ran out

    // lines start parked, clock low
    initial begin
        scl_drv = 1'b0;
        sda_drv = 1'b1;
    end

    // park both lines for half a clock
    task automatic park(input logic c, input logic d);
        scl_drv = c;
        sda_drv = d;
        #HALF;
    endtask

    // release the clock, then wait for the wire to really rise
    task automatic rise();
        scl_drv = 1'b1;
        for (int i = 0; i < 400 && scl_wire !== 1'b1; i++) #10;
        if (scl_wire !== 1'b1) stalls++;
    endtask

    // one bit by toggling the clock; line read at the rising edge
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        #HALF;
        rise();
        r = sda_wire;
        #HALF;
        scl_drv = 1'b0;
    endtask

    // start: data falls while the clock is high, then clock falls
    task automatic start_cond();
        park(1'b1, 1'b1);
        park(1'b1, 1'b0);
        scl_drv = 1'b0;
    endtask

    // whole byte, msb first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
    endtask
endmodule // serial_bus_master_model

`default_nettype wire

// *** sim/universal_serial_shift_unit_tb_top.sv ***
// self-checking bench of the universal serial shift unit
// assumes the master model drives the pins; wires resolved here
`default_nettype none

module universal_serial_shift_unit_tb_top;
    import serial_shift_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ********************************
    // clock, bus, pins and model state
    // ********************************
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, pslv_q;
    logic        timer_ovf = 1'b0, two_wire = 1'b0;
    logic        data_out, data_oe, clock_out, clock_oe;
    logic        scl_drv, sda_drv, scl_wire, sda_wire, rd_line, din_pin;
    int          n_mismatch = 0, tests_run = 0;
    int          m_data = 0, m_cnt = 0, m_ovf = 0, m_sf = 0;

    // open-drain wires and what each side reads
    assign scl_wire = scl_drv & (clock_oe ? clock_out : 1'b1);
    assign sda_wire = sda_drv & (data_oe ? data_out : 1'b1);
    assign din_pin  = two_wire ? sda_wire : sda_drv;
    assign rd_line  = two_wire ? sda_wire : data_out;

    always #25 clk_sys = ~clk_sys;

    universal_serial_shift_unit i_universal_serial_shift_unit (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TIMER_OVF(timer_ovf),
        .SERIAL_CLOCK_PIN(scl_wire), .SERIAL_DATA_IN_PIN(din_pin),
        .DATA_OUT(data_out), .DATA_OE(data_oe),
        .CLOCK_OUT(clock_out), .CLOCK_OE(clock_oe));

    serial_bus_master_model i_serial_bus_master_model (
        .scl_wire(scl_wire), .sda_wire(rd_line),
        .scl_drv(scl_drv), .sda_drv(sda_drv));

    // ********************************
    // report, bus tasks, reference model
    // ********************************
    task automatic wrap_up();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // one apb transfer; tp pulses the timer in the access cycle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, input logic tp,
                       output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable   <= 1'b1;
        timer_ovf <= tp;
        n = 0;
        do begin
            @(posedge clk_sys);
            timer_ovf <= 1'b0;
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            wrap_up();
        end
        rd = prdata;
        pslv_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, 1'b0, x);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic er, input string nm);
        logic [31:0] x;
        apb(1'b0, a, 32'h0, 1'b0, x);
        chk(nm, e, x);
        chk("error", er, pslv_q);
    endtask

    // model: one counted clock, with or without a shift
    task automatic m_step(input int sh, input int b);
        if (sh != 0) m_data = ((m_data << 1) | b) & 255;
        m_cnt = (m_cnt + 1) % 16;
        if (m_cnt == 0) m_ovf = 1;
    endtask

    task automatic wr_dat(input logic [7:0] d);
        wr(DATA_OFFSET, {24'h0, d});
        m_data = d;
    endtask

    // status write: loads counter, ones clear flags
    task automatic wr_st(input logic [7:0] d);
        wr(STATUS_OFFSET, {24'h0, d});
        m_cnt = d[3:0];
        if (d[6]) m_ovf = 0;
        if (d[7]) m_sf = 0;
    endtask

    task automatic cmp();
        rdc(DATA_OFFSET, m_data, 1'b0, "data");
        rdc(STATUS_OFFSET, (m_sf << 7) | (m_ovf << 6) | m_cnt, 1'b0,
            "status");
    endtask

    // ********************************
    // scenarios
    // ********************************
    initial begin
        #2000000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        logic [7:0]  tx, rx, sv;
        logic [31:0] x;
        logic        a;
        int          b;
        x = $urandom(32'h22a4);
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // reset values and an unmapped place
        rdc(DATA_OFFSET, DATA_RST, 1'b0, "data");
        rdc(STATUS_OFFSET, 32'h0, 1'b0, "status");
        rdc(CTRL_OFFSET, CTRL_RST, 1'b0, "ctrl");
        rdc(8'h0c, 32'h0, 1'b1, "unmapped");
        // software strobes from counter 13 through the wrap
        wr_dat(8'($urandom));
        wr_st(8'h0d);
        for (b = 0; b < 3; b++) begin
            i_serial_bus_master_model.park(1'b0, b[0]);
            wr(CTRL_OFFSET, 32'h2);
            m_step(1, b % 2);
            cmp();
        end
        wr_st(8'h00);
        cmp();
        wr_st(8'h40);
        cmp();
        // companion timer as clock, then a write against a shift
        wr(CTRL_OFFSET, 32'h4);
        for (b = 0; b < 3; b++) begin
            @(posedge clk_sys);
            timer_ovf <= 1'b1;
            @(posedge clk_sys);
            timer_ovf <= 1'b0;
            m_step(1, 0);
        end
        cmp();
        tx = 8'($urandom);
        apb(1'b1, DATA_OFFSET, {24'h0, tx}, 1'b1, x);
        rdc(DATA_OFFSET, tx, 1'b0, "data");
        m_data = tx;
        wr_st(8'h00);
        // pin clocked byte exchange, outputs off then three-wire
        for (int wm = 0; wm < 2; wm++) begin
            tx = 8'($urandom);
            sv = 8'($urandom);
            wr(CTRL_OFFSET, (wm << 4) | 32'h8);
            wr_dat(~sv);
            wr_dat(sv);
            wr_st(8'h40);
            if (wm == 1) chk("dout", sv[7], data_out);
            i_serial_bus_master_model.xfer(tx, rx);
            for (b = 7; b >= 0; b--) begin
                m_step(1, tx[b]);
                m_step(0, 0);
            end
            repeat (6) @(posedge clk_sys);
            cmp();
            if (wm == 1) chk("rx", sv, rx);
        end
        // internal clock keeps the latch open in three-wire mode
        wr(CTRL_OFFSET, 32'h10);
        wr_dat(8'($urandom));
        repeat (2) @(posedge clk_sys);
        chk("dout", m_data[7], data_out);
        wr(CTRL_OFFSET, 32'h18);
        // counter at its top value overflows on one pin edge
        wr_st(8'h4f);
        i_serial_bus_master_model.park(1'b0, 1'b1);
        i_serial_bus_master_model.park(1'b1, 1'b1);
        m_step(1, 1);
        cmp();
        i_serial_bus_master_model.park(1'b0, 1'b1);
        m_step(0, 0);
        // two-wire slave: start, hold, address, acknowledge
        wr_dat(8'hff);
        two_wire = 1'b1;
        for (b = 0; b < 2; b++) begin
            wr(CTRL_OFFSET, 32'h28 | (b << 4));
            i_serial_bus_master_model.start_cond();
            m_step(1, 1);
            m_step(0, 0);
            m_sf = 1;
            repeat (8) @(posedge clk_sys);
            chk("hold", 1, clock_oe);
            cmp();
            wr_st(8'hc0);
            repeat (4) @(posedge clk_sys);
            chk("hold", 0, clock_oe);
        end
        tx = 8'($urandom) | 8'h80;
        i_serial_bus_master_model.xfer(tx, rx);
        for (b = 7; b >= 0; b--) begin
            m_step(1, tx[b]);
            m_step(0, 0);
        end
        repeat (6) @(posedge clk_sys);
        chk("hold", 1, clock_oe);
        cmp();
        wr_dat(8'h7f);
        wr_st(8'h4e);
        i_serial_bus_master_model.bit_io(1'b1, a);
        m_step(1, 0);
        m_step(0, 0);
        repeat (6) @(posedge clk_sys);
        chk("ack", 0, a);
        chk("hold", 1, clock_oe);
        cmp();
        chk("clkout", 0, clock_out);
        // master waits out the overflow hold before the clock goes high
        fork
            i_serial_bus_master_model.rise();
            begin
                repeat (10) @(posedge clk_sys);
                wr_st(8'h40);
            end
        join
        m_step(1, 1);
        i_serial_bus_master_model.park(1'b1, 1'b1);
        i_serial_bus_master_model.park(1'b0, 1'b1);
        m_step(0, 0);
        cmp();
        chk("stalls", 0, i_serial_bus_master_model.stalls);
        wrap_up();
    end
endmodule // universal_serial_shift_unit_tb_top

`default_nettype wire
